/* rtl/itg_cfg.svh */
// Register offsets, field positions and reset values of the bus timing generator.
`ifndef ITG_CFG_SVH
`define ITG_CFG_SVH
`define ITG_OFF_DIVIDER 12'h000
`define ITG_OFF_START 12'h004
`define ITG_OFF_STOP_IDLE 12'h008
`define ITG_OFF_DATA_SH 12'h00C
`define ITG_OFF_CLOCK_HL 12'h010
`define ITG_OFF_STATUS 12'h014
`define ITG_LO_LSB 0
`define ITG_HI_LSB 16
`define ITG_FIELD_W 16
`define ITG_RST_US_DIV 16'h0063
`define ITG_RST_MS_DIV 16'h03E7
`define ITG_RST_START_SETUP 16'h01D7
`define ITG_RST_START_HOLD 16'h0191
`define ITG_RST_STOP_SETUP 16'h0191
`define ITG_RST_BUS_IDLE_WAIT_COUNT 16'h0033
`define ITG_RST_DATA_SETUP 16'h007E
`define ITG_RST_DATA_HOLD 16'h001F
`define ITG_RST_SCL_HIGH 16'h01F4
`define ITG_RST_SCL_LOW 16'h01F4
`endif

/* rtl/itg_pkg.sv */
// Types shared by the bus timing generator modules.
package itg_pkg;
  typedef enum logic [2:0] {
    ITG_PH_START_SETUP = 3'b000,
    ITG_PH_START_HOLD = 3'b001,
    ITG_PH_STOP_SETUP = 3'b010,
    ITG_PH_STOP_HOLD = 3'b011,
    ITG_PH_SCL_HIGH = 3'b100,
    ITG_PH_SCL_LOW = 3'b101,
    ITG_PH_DATA_SETUP = 3'b110,
    ITG_PH_DATA_HOLD = 3'b111
  } itg_phase_type;

  typedef enum logic {
    ITG_ENG_IDLE = 1'b0,
    ITG_ENG_RUN = 1'b1
  } itg_eng_type;

  typedef struct packed {
    logic [15:0] us_div;
    logic [15:0] ms_div;
    logic [15:0] start_setup;
    logic [15:0] start_hold;
    logic [15:0] stop_setup;
    logic [15:0] bus_idle_wait_count;
    logic [15:0] data_setup;
    logic [15:0] data_hold;
    logic [15:0] scl_high;
    logic [15:0] scl_low;
  } itg_timing_type;
endpackage

/* rtl/itg_tick_if.sv */
// Divider settings and tick strobes passed between the timing core and the tick generator.
`timescale 1ns/10ps
interface itg_tick_if;
  logic [15:0] us_div;
  logic [15:0] ms_div;
  logic us_tick;
  logic ms_tick;
  modport gen (input us_div, input ms_div, output us_tick, output ms_tick);
  modport user (output us_div, output ms_div, input us_tick, input ms_tick);
endinterface

/* rtl/itg_tick_gen.sv */
// Free running microsecond and millisecond tick dividers.
`timescale 1ns/10ps
module itg_tick_gen (
  input logic core_clk,
  input logic rstn,
  itg_tick_if.gen tick
);
  import itg_pkg::*;

  logic [15:0] us_cnt_q, us_cnt_d, ms_cnt_q, ms_cnt_d;
  logic us_tick_q, us_tick_d, ms_tick_q, ms_tick_d;

  // Both dividers run from reset onward; a compare of greater-or-equal keeps a shrunken divider from wrapping.
  always_comb begin
    us_tick_d = (us_cnt_q >= tick.us_div);
    us_cnt_d = us_tick_d ? 16'h0000 : us_cnt_q + 16'h0001;
    ms_cnt_d = ms_cnt_q;
    ms_tick_d = 1'b0;
    if (us_tick_d) begin
      ms_tick_d = (ms_cnt_q >= tick.ms_div);
      ms_cnt_d = ms_tick_d ? 16'h0000 : ms_cnt_q + 16'h0001;
    end
  end

  // Divider state registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      us_cnt_q <= 16'h0000;
      ms_cnt_q <= 16'h0000;
      us_tick_q <= 1'b0;
      ms_tick_q <= 1'b0;
    end else begin
      us_cnt_q <= us_cnt_d;
      ms_cnt_q <= ms_cnt_d;
      us_tick_q <= us_tick_d;
      ms_tick_q <= ms_tick_d;
    end
  end

  assign tick.us_tick = us_tick_q;
  assign tick.ms_tick = ms_tick_q;

  // Helper that measures the gap between ticks while the divider stays put.
  logic [16:0] gap_q;
  logic steady_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gap_q <= 17'h00000;
      steady_q <= 1'b0;
    end else begin
      gap_q <= us_tick_q ? 17'h00001 : gap_q + 17'h00001;
      steady_q <= us_tick_q ? 1'b1 : (steady_q && $stable(tick.us_div));
    end
  end

  a_us_tick_period: assert property (@(posedge core_clk) disable iff (!rstn)
    (us_tick_q && steady_q && $stable(tick.us_div)) |-> (gap_q == {1'b0, tick.us_div} + 17'h00001))
    else $error("Microsecond tick period differs from divider plus one.");
  a_ms_on_us_tick: assert property (@(posedge core_clk) disable iff (!rstn)
    ms_tick_q |-> us_tick_q)
    else $error("Millisecond tick seen without a microsecond tick.");
endmodule

/* rtl/itg_timing_core.sv */
// Two-wire bus timing generator: APB registers, boot shadowing, phase timers and idle detect.
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/10ps
`include "itg_cfg.svh"
// Contract
// - Microsecond tick period is clock period times divider plus one; reset 0x0063.
// - Millisecond tick period is microsecond period times divider plus one; reset 0x03E7.
// - Timer writes during boot load take effect only after boot load ends.
// - Start setup needs clock and data high for start-setup clocks; reset 0x01D7.
// - Stop hold reuses the start-setup count; no separate setting.
// - After data seen low, wait start-hold clocks before clock low; reset 0x0191.
// - Stop setup needs clock high, data low for stop-setup clocks; reset 0x0191.
// - After reset, bus idle once clock high for idle-detect ticks; reset 0x0033.
// - Before a master transaction, both lines high for the idle-detect period.
// - Idle-detect count of zero makes the bus idle at once.
// - Data driven at least data-setup clocks before clock rise; reset 0x007E.
// - Data held at least data-hold clocks after clock fall; reset 0x001F.
// - Timing settings are shadowed during boot load against rewrites.
// - Master clock high and low phases come from programmable counts.
// - Clock high and low last count clocks each; both reset 0x01F4.
module itg_timing_core (
  input logic core_clk,
  input logic rstn,
  input logic [11:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic boot_load_active,
  input logic scl_pin_in,
  input logic serial_data_pin_in,
  input logic phase_start,
  input itg_pkg::itg_phase_type phase_sel,
  output logic phase_busy,
  output logic phase_done,
  output logic bus_idle,
  output logic us_tick,
  output logic ms_tick
);
  import itg_pkg::*;

  // True for every address that holds a register.
  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `ITG_OFF_DIVIDER) || (a == `ITG_OFF_START) || (a == `ITG_OFF_STOP_IDLE) ||
                  (a == `ITG_OFF_DATA_SH) || (a == `ITG_OFF_CLOCK_HL) || (a == `ITG_OFF_STATUS);
  endfunction

  // Count that governs a phase; stop hold borrows the start setup value.
  function automatic logic [15:0] phase_count(input itg_phase_type p, input itg_timing_type t);
    unique case (p)
      ITG_PH_START_SETUP: phase_count = t.start_setup;
      ITG_PH_START_HOLD: phase_count = t.start_hold;
      ITG_PH_STOP_SETUP: phase_count = t.stop_setup;
      ITG_PH_STOP_HOLD: phase_count = t.start_setup;
      ITG_PH_SCL_HIGH: phase_count = t.scl_high;
      ITG_PH_SCL_LOW: phase_count = t.scl_low;
      ITG_PH_DATA_SETUP: phase_count = t.data_setup;
      ITG_PH_DATA_HOLD: phase_count = t.data_hold;
    endcase
  endfunction

  // Line state a phase insists on; a lapse restarts the count.
  function automatic logic phase_cond(input itg_phase_type p, input logic scl, input logic sda);
    unique case (p)
      ITG_PH_START_SETUP: phase_cond = scl && sda;
      ITG_PH_STOP_HOLD: phase_cond = scl && sda;
      ITG_PH_START_HOLD: phase_cond = !sda;
      ITG_PH_STOP_SETUP: phase_cond = scl && !sda;
      default: phase_cond = 1'b1;
    endcase
  endfunction

  localparam itg_timing_type TIMING_RST = '{us_div: `ITG_RST_US_DIV, ms_div: `ITG_RST_MS_DIV,
    start_setup: `ITG_RST_START_SETUP, start_hold: `ITG_RST_START_HOLD, stop_setup: `ITG_RST_STOP_SETUP,
    bus_idle_wait_count: `ITG_RST_BUS_IDLE_WAIT_COUNT, data_setup: `ITG_RST_DATA_SETUP, data_hold: `ITG_RST_DATA_HOLD,
    scl_high: `ITG_RST_SCL_HIGH, scl_low: `ITG_RST_SCL_LOW};

  itg_timing_type soft_q, soft_d, act_q, act_d;
  logic [31:0] prdata_q, prdata_d;
  logic [1:0] sync1_q, sync2_q, sync3_q, lines_q, lines_d;
  logic scl_s, sda_s;
  itg_eng_type eng_q, eng_d;
  itg_phase_type ph_q, ph_d;
  logic [15:0] cnt_q, cnt_d, icnt_q, icnt_d;
  logic done_q, done_d, idle_q, idle_d, seen_q, seen_d, idle_cond;
  logic apb_wr, apb_rd_setup;

  // Register bus: zero wait states, error only on an unmapped address.
  assign apb_wr = psel && penable && pwrite && addr_mapped(paddr);
  assign apb_rd_setup = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);

  // Software copy of the settings, written in the access cycle, and the read data, captured in the setup cycle.
  always_comb begin
    soft_d = soft_q;
    prdata_d = prdata_q;
    if (apb_wr) begin
      unique case (paddr)
        `ITG_OFF_DIVIDER: {soft_d.ms_div, soft_d.us_div} = pwdata;
        `ITG_OFF_START: {soft_d.start_hold, soft_d.start_setup} = pwdata;
        `ITG_OFF_STOP_IDLE: {soft_d.bus_idle_wait_count, soft_d.stop_setup} = pwdata;
        `ITG_OFF_DATA_SH: {soft_d.data_hold, soft_d.data_setup} = pwdata;
        `ITG_OFF_CLOCK_HL: {soft_d.scl_low, soft_d.scl_high} = pwdata;
        default: soft_d = soft_q;
      endcase
    end
    if (apb_rd_setup) begin
      unique case (paddr)
        `ITG_OFF_DIVIDER: prdata_d = {soft_q.ms_div, soft_q.us_div};
        `ITG_OFF_START: prdata_d = {soft_q.start_hold, soft_q.start_setup};
        `ITG_OFF_STOP_IDLE: prdata_d = {soft_q.bus_idle_wait_count, soft_q.stop_setup};
        `ITG_OFF_DATA_SH: prdata_d = {soft_q.data_hold, soft_q.data_setup};
        `ITG_OFF_CLOCK_HL: prdata_d = {soft_q.scl_low, soft_q.scl_high};
        `ITG_OFF_STATUS: prdata_d = {26'h0000000, seen_q, bus_idle, eng_q == ITG_ENG_RUN,
                                     boot_load_active, sda_s, scl_s};
        default: prdata_d = 32'h00000000;
      endcase
    end
  end

  // The active set freezes for the whole boot load so the EEPROM being read keeps its timing.
  assign act_d = boot_load_active ? act_q : soft_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_q <= TIMING_RST;
      act_q <= TIMING_RST;
      prdata_q <= 32'h00000000;
    end else begin
      soft_q <= soft_d;
      act_q <= act_d;
      prdata_q <= prdata_d;
    end
  end
  assign prdata = prdata_q;

  // Pin synchronisers: a level is accepted only once the second and third stages agree.
  always_comb begin
    lines_d = lines_q;
    for (int i = 0; i < 2; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        lines_d[i] = sync3_q[i];
      end
    end
  end

  // Released lines idle high, so the filtered state starts high.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= 2'h3;
      sync2_q <= 2'h3;
      sync3_q <= 2'h3;
      lines_q <= 2'h3;
    end else begin
      sync1_q <= {serial_data_pin_in, scl_pin_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lines_q <= lines_d;
    end
  end
  assign scl_s = lines_q[0];
  assign sda_s = lines_q[1];

  // Tick generator fed from the active, shadowed divider values.
  itg_tick_if tick_bus ();
  assign tick_bus.us_div = act_q.us_div;
  assign tick_bus.ms_div = act_q.ms_div;
  itg_tick_gen u_tick (
    .core_clk(core_clk),
    .rstn(rstn),
    .tick(tick_bus.gen)
  );
  assign us_tick = tick_bus.us_tick;
  assign ms_tick = tick_bus.ms_tick;

  // Phase engine: a new request always restarts the timer, even mid-phase.
  always_comb begin
    eng_d = eng_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (phase_start) begin
      eng_d = ITG_ENG_RUN;
      ph_d = phase_sel;
      cnt_d = phase_count(phase_sel, act_q);
    end else begin
      unique case (eng_q)
        ITG_ENG_IDLE: cnt_d = cnt_q;
        ITG_ENG_RUN: begin
          if (!phase_cond(ph_q, scl_s, sda_s)) begin
            cnt_d = phase_count(ph_q, act_q);
          end else if (cnt_q <= 16'h0001) begin
            done_d = 1'b1;
            eng_d = ITG_ENG_IDLE;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      eng_q <= ITG_ENG_IDLE;
      ph_q <= ITG_PH_START_SETUP;
      cnt_q <= 16'h0000;
      done_q <= 1'b0;
    end else begin
      eng_q <= eng_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end
  assign phase_busy = (eng_q == ITG_ENG_RUN);
  assign phase_done = done_q;

  // Idle detect: clock alone until the first idle after reset, both lines from then on.
  assign idle_cond = seen_q ? (scl_s && sda_s) : scl_s;
  always_comb begin
    icnt_d = icnt_q;
    idle_d = idle_q;
    seen_d = seen_q;
    if (!idle_cond) begin
      icnt_d = 16'h0000;
      idle_d = 1'b0;
    end else if (act_q.bus_idle_wait_count == 16'h0000) begin
      seen_d = 1'b1;
    end else if (!idle_q && us_tick) begin
      icnt_d = icnt_q + 16'h0001;
      if (icnt_d >= act_q.bus_idle_wait_count) begin
        idle_d = 1'b1;
        seen_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      icnt_q <= 16'h0000;
      idle_q <= 1'b0;
      seen_q <= 1'b0;
    end else begin
      icnt_q <= icnt_d;
      idle_q <= idle_d;
      seen_q <= seen_d;
    end
  end
  // A zero count skips the wait entirely.
  assign bus_idle = idle_q || (act_q.bus_idle_wait_count == 16'h0000);

  // Helpers for the checks: cycles since phase start and run of the required line state.
  logic [16:0] elap_q, run_q;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      elap_q <= 17'h00000;
      run_q <= 17'h00000;
    end else if (phase_start) begin
      elap_q <= 17'h00000;
      run_q <= 17'h00000;
    end else if (phase_busy) begin
      elap_q <= elap_q + 17'h00001;
      run_q <= phase_cond(ph_q, scl_s, sda_s) ? run_q + 17'h00001 : 17'h00000;
    end
  end

  a_start_setup_run: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_START_SETUP) |-> run_q >= {1'b0, act_q.start_setup})
    else $error("Start setup ended before the lines were high long enough.");
  a_stop_hold_reuse: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_STOP_HOLD) |-> run_q >= {1'b0, act_q.start_setup})
    else $error("Stop hold did not use the start setup count.");
  a_start_hold_len: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_START_HOLD) |-> run_q >= {1'b0, act_q.start_hold})
    else $error("Start hold shorter than programmed.");
  a_stop_setup_run: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_STOP_SETUP) |-> run_q >= {1'b0, act_q.stop_setup})
    else $error("Stop setup ended before the lines held long enough.");
  a_scl_high_len: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_SCL_HIGH && act_q.scl_high != 16'h0000 && $stable(act_q.scl_high))
    |-> elap_q == {1'b0, act_q.scl_high})
    else $error("Clock high phase length differs from its count.");
  a_data_setup_len: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_DATA_SETUP && act_q.data_setup != 16'h0000) |-> elap_q >= {1'b0, act_q.data_setup})
    else $error("Data setup shorter than programmed.");
  a_data_hold_len: assert property (@(posedge core_clk) disable iff (!rstn)
    (phase_done && ph_q == ITG_PH_DATA_HOLD && act_q.data_hold != 16'h0000) |-> elap_q >= {1'b0, act_q.data_hold})
    else $error("Data hold shorter than programmed.");
  a_boot_shadow_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (boot_load_active && $past(boot_load_active)) |-> $stable(act_q))
    else $error("Active timing changed during boot load.");
  a_shadow_release: assert property (@(posedge core_clk) disable iff (!rstn)
    (!boot_load_active ##1 $stable(soft_q)) |-> act_q == soft_q)
    else $error("Active timing did not follow software after boot load.");
  a_idle_zero_now: assert property (@(posedge core_clk) disable iff (!rstn)
    (act_q.bus_idle_wait_count == 16'h0000) |-> bus_idle)
    else $error("Zero idle count did not give an idle bus.");
  a_idle_after_wait: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(idle_q) |-> ($past(icnt_q) + 16'h0001 >= act_q.bus_idle_wait_count) && $past(idle_cond))
    else $error("Bus called idle before the idle wait ran out.");

  c_start_done: cover property (@(posedge core_clk) disable iff (!rstn)
    phase_done && ph_q == ITG_PH_START_SETUP);
  c_boot_write: cover property (@(posedge core_clk) disable iff (!rstn)
    boot_load_active && apb_wr);
  c_idle_seen: cover property (@(posedge core_clk) disable iff (!rstn) $rose(idle_q));
endmodule

/* bench/itg_line_model.sv */
// Far-side model of the two pulled-up bus lines as other bus devices hold them.
`timescale 1ns/10ps
module itg_line_model (
  input logic hold_scl_low,
  input logic hold_sda_low,
  output logic scl_level,
  output logic sda_level
);
  // Both lines are open drain with a pull-up, so a released line reads high at once.
  assign scl_level = hold_scl_low ? 1'b0 : 1'b1;
  assign sda_level = hold_sda_low ? 1'b0 : 1'b1;
endmodule

/* bench/itg_timing_core_bench.sv */
// Self-checking bench for the bus timing generator.
`timescale 1ns/10ps
`include "itg_cfg.svh"
module itg_timing_core_bench;
  import itg_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, phase_busy, phase_done, bus_idle, us_tick, ms_tick;
  logic boot_load_active = 1'b0;
  logic phase_start = 1'b0;
  itg_phase_type phase_sel = ITG_PH_START_SETUP;
  logic pull_scl = 1'b0;
  logic pull_sda = 1'b0;
  logic scl_line, sda_line;
  int miscompares = 0;
  int n_compared = 0;
  logic [31:0] rd;
  logic err;
  int cnt;

  // Free running system clock.
  always #2 core_clk = ~core_clk;

  itg_line_model u_lines (.hold_scl_low(pull_scl), .hold_sda_low(pull_sda), .scl_level(scl_line),
    .sda_level(sda_line));

  itg_timing_core u_dut (.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .boot_load_active(boot_load_active), .scl_pin_in(scl_line), .serial_data_pin_in(sda_line),
    .phase_start(phase_start), .phase_sel(phase_sel), .phase_busy(phase_busy), .phase_done(phase_done),
    .bus_idle(bus_idle), .us_tick(us_tick), .ms_tick(ms_tick));

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Compares one value; case equality keeps unknowns from matching.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that ran out of its bound counts as a mismatch and closes the run.
  task automatic hang();
    chk(32'h00000000, 32'h00000001);
    tally_and_finish();
  endtask

  // One APB transfer, entered just after a rising edge; holds everything until pready is seen.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) hang();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Requests one phase and returns the number of busy cycles before its done pulse.
  task automatic run_phase(input itg_phase_type s, input int tmo, output int c);
    int i;
    phase_start <= 1'b1;
    phase_sel <= s;
    @(posedge core_clk);
    phase_start <= 1'b0;
    c = 0;
    for (i = 0; i < tmo; i++) begin
      @(negedge core_clk);
      if (phase_done === 1'b1) break;
      if (phase_busy === 1'b1) c++;
    end
    if (i == tmo) hang();
    @(posedge core_clk);
  endtask

  // Measures the clocks from one tick to the next; a millisecond tick must land on a microsecond tick.
  task automatic tick_gap(input logic ms, output int n);
    int i;
    int seen;
    n = 0;
    seen = 0;
    for (i = 0; i < 2000 && seen < 2; i++) begin
      @(negedge core_clk);
      if (seen == 1) n++;
      if ((ms ? ms_tick : us_tick) === 1'b1) begin
        seen++;
        if (ms) chk({31'b0, us_tick}, 32'h00000001);
      end
    end
    if (seen < 2) hang();
    @(posedge core_clk);
  endtask

  // Idle after reset needs the clock line high for 0x33 microsecond ticks of 100 clocks.
  task automatic t_idle_reset();
    int i;
    cnt = 0;
    for (i = 0; i < 6000; i++) begin
      @(negedge core_clk);
      if (bus_idle === 1'b1) break;
      cnt++;
    end
    chk({31'b0, cnt >= 5050 && cnt <= 5150}, 32'h00000001);
    @(posedge core_clk);
    pull_sda <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({31'b0, bus_idle}, 32'h00000000);
    pull_sda <= 1'b0;
    $display("test idle_reset done");
  endtask

  // Reset values of every field, then the unmapped and read-only places.
  task automatic t_regs();
    logic [11:0] offs[5];
    logic [31:0] exps[5];
    offs = '{`ITG_OFF_DIVIDER, `ITG_OFF_START, `ITG_OFF_STOP_IDLE, `ITG_OFF_DATA_SH, `ITG_OFF_CLOCK_HL};
    exps = '{{`ITG_RST_MS_DIV, `ITG_RST_US_DIV}, {`ITG_RST_START_HOLD, `ITG_RST_START_SETUP},
      {`ITG_RST_BUS_IDLE_WAIT_COUNT, `ITG_RST_STOP_SETUP}, {`ITG_RST_DATA_HOLD, `ITG_RST_DATA_SETUP},
      {`ITG_RST_SCL_LOW, `ITG_RST_SCL_HIGH}};
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, offs[k], 32'h00000000, rd, err);
      chk(rd, exps[k]);
    end
    apb(1'b1, 12'h018, 32'h12345678, rd, err);
    chk({31'b0, err}, 32'h00000001);
    apb(1'b0, 12'h018, 32'h00000000, rd, err);
    chk({rd[30:0], err}, 32'h00000001);
    apb(1'b1, `ITG_OFF_STATUS, 32'hFFFFFFFF, rd, err);
    chk({31'b0, err}, 32'h00000000);
    $display("test regs done");
  endtask

  // Default microsecond period, then short dividers for both ticks.
  task automatic t_ticks();
    tick_gap(1'b0, cnt);
    chk(cnt, 32'h00000064);
    apb(1'b1, `ITG_OFF_DIVIDER, 32'h00020004, rd, err);
    tick_gap(1'b0, cnt);
    chk(cnt, 32'h00000005);
    tick_gap(1'b1, cnt);
    chk(cnt, 32'h0000000F);
    $display("test ticks done");
  endtask

  // Every phase kind with its count, stop hold borrowing the start setup one; the start and stop phases need their line levels.
  task automatic t_phases();
    itg_phase_type sels[8];
    int n[8];
    sels = '{ITG_PH_SCL_HIGH, ITG_PH_SCL_LOW, ITG_PH_DATA_SETUP, ITG_PH_DATA_HOLD, ITG_PH_START_SETUP,
      ITG_PH_STOP_HOLD, ITG_PH_START_HOLD, ITG_PH_STOP_SETUP};
    n = '{3, 4, 5, 2, 3, 3, 6, 4};
    apb(1'b1, `ITG_OFF_CLOCK_HL, 32'h00040003, rd, err);
    apb(1'b1, `ITG_OFF_DATA_SH, 32'h00020005, rd, err);
    apb(1'b1, `ITG_OFF_START, 32'h00060003, rd, err);
    apb(1'b1, `ITG_OFF_STOP_IDLE, 32'h00330004, rd, err);
    for (int k = 0; k < 8; k++) begin
      if (k == 6) pull_sda <= 1'b1;
      if (k == 6) repeat (8) @(posedge core_clk);
      run_phase(sels[k], 100, cnt);
      chk(cnt, n[k]);
    end
    pull_sda <= 1'b0;
    $display("test phases done");
  endtask

  // Start setup must restart while another device holds the clock line low.
  task automatic t_restart();
    pull_scl <= 1'b1;
    repeat (8) @(posedge core_clk);
    fork
      run_phase(ITG_PH_START_SETUP, 200, cnt);
      begin
        repeat (20) @(posedge core_clk);
        pull_scl <= 1'b0;
      end
    join
    chk({31'b0, cnt >= 22 && cnt <= 32}, 32'h00000001);
    $display("test restart done");
  endtask

  // A write during boot load is readable at once but reaches the timers only after it.
  task automatic t_shadow();
    boot_load_active <= 1'b1;
    apb(1'b1, `ITG_OFF_CLOCK_HL, 32'h00040007, rd, err);
    apb(1'b0, `ITG_OFF_CLOCK_HL, 32'h00000000, rd, err);
    chk(rd, 32'h00040007);
    run_phase(ITG_PH_SCL_HIGH, 100, cnt);
    chk(cnt, 32'h00000003);
    boot_load_active <= 1'b0;
    repeat (2) @(posedge core_clk);
    run_phase(ITG_PH_SCL_HIGH, 100, cnt);
    chk(cnt, 32'h00000007);
    $display("test shadow done");
  endtask

  // A zero idle count reports the bus idle at once, even with the data line low.
  task automatic t_idle_zero();
    pull_sda <= 1'b1;
    apb(1'b1, `ITG_OFF_STOP_IDLE, 32'h00000004, rd, err);
    repeat (3) @(posedge core_clk);
    chk({31'b0, bus_idle}, 32'h00000001);
    pull_sda <= 1'b0;
    $display("test idle_zero done");
  endtask

  // Reset for five cycles, then the scenarios in order.
  initial begin
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    t_idle_reset();
    t_regs();
    t_ticks();
    t_phases();
    t_restart();
    t_shadow();
    t_idle_zero();
    tally_and_finish();
  end
endmodule
